// *** hw/hotswap_pkg.sv ***
// Shared constants and types for the hot-swap status register block
package hotswap_pkg;

  // Register offsets on the serial host port
  localparam logic [7:0] SYS_CFG_OFF  = 8'h06;
  localparam logic [7:0] CH_STAT_OFF  = 8'h07;
  localparam logic [7:0] OC_STAT_OFF  = 8'h08;
  localparam logic [7:0] FET_STAT_OFF = 8'h09;

  // Reset value of the system configuration register
  localparam logic [7:0] SYS_CFG_RST  = 8'h00;

  // System configuration field positions
  localparam int CFG_TEST_FORCE   = 0;
  localparam int CFG_RESTART_SEL  = 1;
  localparam int CFG_POL_RSVD     = 2;
  localparam int CFG_ORING_EN     = 3;
  localparam int CFG_BOOST_EN     = 4;
  localparam int CFG_ONE_RSVD     = 5;
  localparam int CFG_XLINK_DIS    = 7;

  // Latched channel status field positions
  localparam int CH_HI_PG  = 4;
  localparam int CH_HI_TMO = 5;
  localparam int CH_LO_PG  = 6;
  localparam int CH_LO_TMO = 7;

  // Latched overcurrent status field positions
  localparam int OC_HI_LIM  = 4;
  localparam int OC_HI_TRIP = 5;
  localparam int OC_LO_LIM  = 6;
  localparam int OC_LO_TRIP = 7;

  // Live FET status field positions
  localparam int FET_HI_BLOCK  = 3;
  localparam int FET_HI_SERIES = 4;
  localparam int FET_LO_BLOCK  = 5;
  localparam int FET_LO_GATE   = 7;

  // Timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int FAST_OFF_NS      = 15000;
  localparam int FAST_OFF_CYCLES  = FAST_OFF_NS / CLK_PERIOD_NS;
  localparam int FAULT_LSB_NS     = 450000;
  localparam int FAULT_LSB_CYCLES = FAULT_LSB_NS / CLK_PERIOD_NS;
  localparam int RETRY_FACTOR     = 100;

  // Limit code forced during inrush boost
  localparam logic [3:0] LIMIT_MAX = 4'hF;

  // Per-channel restart state
  typedef enum logic [1:0] {
    CH_RUN,
    CH_WAIT,
    CH_LATCH
  } chan_e;

  // Serial target state
  typedef enum logic [2:0] {
    SER_IDLE,
    SER_ADDR,
    SER_ACK_A,
    SER_PTR,
    SER_ACK_W,
    SER_WDATA,
    SER_RDATA,
    SER_RACK
  } ser_e;

endpackage

// *** hw/serial_target.sv ***
// Two-wire serial target: device address, register pointer, byte access
`timescale 1ns/1ns
module serial_target
  import hotswap_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary value
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);

  typedef struct packed {
    ser_e       st;
    logic       scl_q;
    logic       sda_q;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic       rw;
    logic [7:0] ptr;
    logic       drv;
  } ser_s;

  ser_s s;
  ser_s next_s;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  // Bus conditions from last and present samples
  assign scl_rise = scl_in & ~s.scl_q;
  assign scl_fall = ~scl_in & s.scl_q;
  assign start_c  = scl_in & s.scl_q & s.sda_q & ~sda_in;
  assign stop_c   = scl_in & s.scl_q & ~s.sda_q & sda_in;

  // Strobes are combinational so a read clears in the cycle it samples
  assign reg_rd    = scl_fall & ~start_c & ~stop_c & (s.st == SER_ACK_A)
                     & s.rw;
  assign reg_wr    = scl_fall & (s.st == SER_WDATA) & (s.cnt == 4'h8);
  assign reg_addr  = s.ptr;
  assign reg_wdata = s.sh;
  assign sda_out   = 1'b0;  // Open drain: only ever pulls low
  assign sda_oe    = s.drv;

  // Byte engine
  always_comb begin
    next_s = s;
    next_s.scl_q = scl_in;
    next_s.sda_q = sda_in;
    if (start_c) begin
      next_s.st  = SER_ADDR;
      next_s.cnt = 4'h0;
      next_s.drv = 1'b0;
    end else if (stop_c) begin
      next_s.st  = SER_IDLE;
      next_s.drv = 1'b0;
    end else if (scl_rise) begin
      unique case (s.st)
        SER_ADDR, SER_PTR, SER_WDATA: begin
          next_s.sh  = {s.sh[6:0], sda_in};
          next_s.cnt = s.cnt + 4'h1;
        end
        SER_RDATA: next_s.cnt = s.cnt + 4'h1;
        SER_RACK: next_s.st = sda_in ? SER_IDLE : SER_ACK_A;
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (s.st)
        SER_ADDR: if (s.cnt == 4'h8) begin
          if (s.sh[7:1] == DEV_ADDR) begin
            next_s.drv = 1'b1;
            next_s.rw  = s.sh[0];
            next_s.st  = SER_ACK_A;
          end else begin
            next_s.st = SER_IDLE;
          end
        end
        SER_ACK_A: begin
          next_s.cnt = 4'h0;
          if (s.rw) begin
            next_s.sh  = reg_rdata;
            next_s.drv = ~reg_rdata[7];
            next_s.ptr = s.ptr + 8'h01;
            next_s.st  = SER_RDATA;
          end else begin
            next_s.drv = 1'b0;
            next_s.st  = SER_PTR;
          end
        end
        SER_PTR: if (s.cnt == 4'h8) begin
          next_s.ptr = s.sh;
          next_s.drv = 1'b1;
          next_s.st  = SER_ACK_W;
        end
        SER_WDATA: if (s.cnt == 4'h8) begin
          next_s.ptr = s.ptr + 8'h01;
          next_s.drv = 1'b1;
          next_s.st  = SER_ACK_W;
        end
        SER_ACK_W: begin
          next_s.drv = 1'b0;
          next_s.cnt = 4'h0;
          next_s.st  = SER_WDATA;
        end
        SER_RDATA: if (s.cnt == 4'h8) begin
          next_s.drv = 1'b0;  // Release for host acknowledge
          next_s.st  = SER_RACK;
        end else begin
          next_s.sh  = {s.sh[6:0], 1'b0};
          next_s.drv = ~s.sh[6];
        end
        default: ;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '{st: SER_IDLE, scl_q: 1'b1, sda_q: 1'b1, sh: 8'h00,
             cnt: 4'h0, rw: 1'b0, ptr: 8'h00, drv: 1'b0};
    end else begin
      s <= next_s;
    end
  end

endmodule

// *** hw/hotswap_regs.sv ***
// System configuration, latched status and restart control registers
//
// Operation
// - Test force holds fast turnoff drivers on
// - Restart select retries after 100 fault times
// - Restart select clear latches timed-out channel
// - One restart select bit governs all channels
// - Cross-linked high rail waits for enable cycle
// - Cross link disable decides low fault shutdown
// - ORing enable gates low rail reverse turnoff
// - Inrush boost forces maximum limit code
// - High rail power-good flag latches until read
// - High rail timeout flag latches until read
// - Low rail power-good flag latches until read
// - Low rail timeout flag latches until read
// - Power-good flags also set at turn-on
// - High rail limit flag, also set at turn-on
// - High rail fast trip flag, also at turn-on
// - Low rail limit flag latches until read
// - Low rail fast trip flag latches until read
// - Live high rail block status bit
// - Series status reads low when gate high
// - Low rail block status low when on
// - Low rail gate status low above 1.75 V
`timescale 1ns/1ns
module hotswap_regs
  import hotswap_pkg::*;
#(
  parameter int         FAULT_TICK = FAULT_LSB_CYCLES,
  parameter logic [6:0] DEV_ADDR   = 7'h2A  // Arbitrary value
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       high_rail_enable,
  input  wire logic       low_rail_enable,
  input  wire logic [4:0] high_rail_fault_code,
  input  wire logic [4:0] low_rail_fault_code,
  input  wire logic [3:0] high_rail_limit_code,
  input  wire logic       high_rail_on,
  input  wire logic       low_rail_on,
  input  wire logic       high_rail_pg_low,
  input  wire logic       low_rail_pg_low,
  input  wire logic       high_rail_timer_done,
  input  wire logic       low_rail_timer_done,
  input  wire logic       high_rail_in_limit,
  input  wire logic       high_rail_trip,
  input  wire logic       low_rail_in_limit,
  input  wire logic       low_rail_trip,
  input  wire logic       low_rail_reverse,
  input  wire logic       high_rail_block_cmd,
  input  wire logic       high_rail_series_on,
  input  wire logic       low_rail_oring_on,
  input  wire logic       low_rail_gate_on,
  output logic            fast_off_drive,
  output logic            high_rail_allow,
  output logic            low_rail_allow,
  output logic [3:0]      high_rail_limit_eff,
  output logic            low_rail_reverse_off,
  output logic            low_rail_oring_active
);

  // Counter widths follow the counts, so a short simulation tick
  // leaves no unused bits behind
  localparam int FAST_W = $clog2(FAST_OFF_CYCLES + 1);
  localparam int TICK_W = $clog2(FAULT_TICK + 1);
  localparam logic [FAST_W-1:0] FAST_LOAD = FAST_W'(FAST_OFF_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(FAULT_TICK - 1);

  // All state of the block in one record, registered in one place
  typedef struct packed {
    logic [7:0]              cfg;
    logic [7:0]              ch_flags;
    logic [7:0]              oc_flags;
    logic [FAST_W-1:0]       fast_cnt;
    logic [TICK_W-1:0]       tick_cnt;
    chan_e [1:0]             ch;
    logic [1:0][11:0]        wait_cnt;
    logic [1:0]              on_q;
    logic [1:0]              en_q;
    logic                    boost;
    logic                    limit_q;
  } regs_s;

  regs_s s;
  regs_s next_s;

  // Register port strobes and per-channel views of the rail inputs
  logic [7:0]       reg_addr;
  logic             reg_wr;
  logic [7:0]       reg_wdata;
  logic             reg_rd;
  logic [7:0]       reg_rdata;
  logic [7:0]       fet_live;
  logic [1:0]       timer_done;
  logic [1:0]       enable;
  logic [1:0]       rail_on;
  logic [1:0][4:0]  fault_code;
  logic [1:0]       turn_on;

  // Offset match shared by read mux and strobe decode
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // Serial host port, the only way software reaches these registers;
  // the address is a parameter so a board can carry several parts
  serial_target #(
    .DEV_ADDR (DEV_ADDR)
  ) u_serial (
    .clock     (clock),
    .rst       (rst),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .sda_out   (sda_out),
    .sda_oe    (sda_oe),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_wdata (reg_wdata),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );

  // Channel index 0 is the high rail, 1 the low rail
  // Turn-on is the rising edge of the rail's on input, seen in the
  // same cycle by comparing it with the registered copy
  assign timer_done = {low_rail_timer_done, high_rail_timer_done};
  assign enable     = {low_rail_enable, high_rail_enable};
  assign rail_on    = {low_rail_on, high_rail_on};
  assign fault_code = {low_rail_fault_code, high_rail_fault_code};
  assign turn_on    = rail_on & ~s.on_q;

  // Live FET status, not latched
  // Follows the comparators directly, so two reads may differ;
  // software wanting a stable view must read twice
  always_comb begin
    fet_live = 8'h00;
    fet_live[FET_HI_BLOCK]  = high_rail_block_cmd;
    fet_live[FET_HI_SERIES] = ~high_rail_series_on;
    fet_live[FET_LO_BLOCK]  = ~low_rail_oring_on;
    fet_live[FET_LO_GATE]   = ~low_rail_gate_on;
  end

  // Read mux; unmapped offsets answer zero
  // The port loads this value on the edge that clears the flags,
  // so the byte shifted out is the state before the clear
  always_comb begin
    if (hit(reg_addr, SYS_CFG_OFF)) begin
      reg_rdata = s.cfg;
    end else if (hit(reg_addr, CH_STAT_OFF)) begin
      reg_rdata = s.ch_flags;
    end else if (hit(reg_addr, OC_STAT_OFF)) begin
      reg_rdata = s.oc_flags;
    end else if (hit(reg_addr, FET_STAT_OFF)) begin
      reg_rdata = fet_live;
    end else begin
      reg_rdata = 8'h00;
    end
  end

  // Control outputs
  // Allow is combinational so a cleared enable drops the rail at
  // once, without waiting for the channel state
  assign fast_off_drive = s.cfg[CFG_TEST_FORCE] | (s.fast_cnt != '0);
  assign high_rail_allow = (s.ch[0] == CH_RUN) & high_rail_enable;
  assign low_rail_allow  = (s.ch[1] == CH_RUN) & low_rail_enable;
  assign high_rail_limit_eff = s.boost ? LIMIT_MAX
                                       : high_rail_limit_code;
  // Cleared enable behaves as if input far exceeds output
  assign low_rail_reverse_off  = low_rail_reverse & s.cfg[CFG_ORING_EN];
  assign low_rail_oring_active = s.cfg[CFG_ORING_EN];

  // Next-state logic for all registers and channel control
  always_comb begin
    logic       tick;
    logic [1:0] shut;
    logic       clr_ch;
    logic       clr_oc;
    logic [7:0] ev_ch;
    logic [7:0] ev_oc;

    tick   = 1'b0;
    shut   = 2'b00;
    clr_ch = 1'b0;
    clr_oc = 1'b0;
    ev_ch  = 8'h00;
    ev_oc  = 8'h00;

    next_s = s;
    next_s.on_q    = rail_on;
    next_s.en_q    = enable;
    next_s.limit_q = high_rail_in_limit;

    // Reserved bits are stored as written; software keeps them legal
    // Status offsets are acked by the port but a write there is lost;
    // latched flags are cleared only by reading them
    if (reg_wr && hit(reg_addr, SYS_CFG_OFF)) begin
      next_s.cfg = reg_wdata;
    end

    // Status events; set wins over a same-cycle read clear
    // Dropping it would hide an event the host never saw, so the
    // clear only removes what was already reported
    clr_ch = reg_rd & hit(reg_addr, CH_STAT_OFF);
    clr_oc = reg_rd & hit(reg_addr, OC_STAT_OFF);
    ev_ch[CH_HI_PG]  = high_rail_pg_low | turn_on[0];
    ev_ch[CH_HI_TMO] = high_rail_timer_done;
    ev_ch[CH_LO_PG]  = low_rail_pg_low | turn_on[1];
    ev_ch[CH_LO_TMO] = low_rail_timer_done;
    ev_oc[OC_HI_LIM]  = high_rail_in_limit | turn_on[0];
    ev_oc[OC_HI_TRIP] = high_rail_trip | turn_on[0];
    ev_oc[OC_LO_LIM]  = low_rail_in_limit;
    ev_oc[OC_LO_TRIP] = low_rail_trip;
    next_s.ch_flags = (s.ch_flags & ~{8{clr_ch}}) | ev_ch;
    next_s.oc_flags = (s.oc_flags & ~{8{clr_oc}}) | ev_oc;

    // Fast turnoff window starts when the high rail drops
    // Every fall reloads the full window, so a rail that bounces off
    // twice gets two whole windows; the test force bit bypasses
    // the counter and holds the drivers on with no limit
    if (~high_rail_on & s.on_q[0]) begin
      next_s.fast_cnt = FAST_LOAD;
    end else if (s.fast_cnt != '0) begin
      next_s.fast_cnt = s.fast_cnt - 1'b1;
    end

    // Prescaler marks one fault-time step
    // Shared by both channels: one counter saved, but a retry may
    // end up to one step early as the wait starts mid-step
    if (s.tick_cnt == TICK_LAST) begin
      next_s.tick_cnt = '0;
      tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 1'b1;
    end

    // Boost from enable until limit is left or timer runs out
    // A rail that never enters limit keeps the boost until its
    // timer or its enable ends it
    if (high_rail_enable & ~s.en_q[0] & s.cfg[CFG_BOOST_EN]) begin
      next_s.boost = 1'b1;
    end else if ((s.limit_q & ~high_rail_in_limit) | high_rail_timer_done
                 | ~high_rail_enable) begin
      next_s.boost = 1'b0;
    end

    // Shutdown causes: each channel's own timeout only; the
    // cross-linked case is handled after the loop below
    shut[0] = timer_done[0];
    shut[1] = timer_done[1];

    // Restart or latch decision, same select bit for each channel
    // The bit is read when the fault lands; changing it during a
    // wait does not turn a pending retry into a latch
    for (int i = 0; i < 2; i++) begin
      unique case (s.ch[i])
        CH_RUN: if (shut[i]) begin
          next_s.wait_cnt[i] = 12'h000;
          next_s.ch[i] = s.cfg[CFG_RESTART_SEL] ? CH_WAIT
                                                : CH_LATCH;
        end
        CH_WAIT: begin
          if (s.wait_cnt[i] >= 12'(RETRY_FACTOR * fault_code[i])) begin
            next_s.ch[i] = CH_RUN;
          end else if (tick) begin
            next_s.wait_cnt[i] = s.wait_cnt[i] + 12'h001;
          end
        end
        CH_LATCH: if (~enable[i]) begin
          next_s.ch[i] = CH_RUN;
        end
        default: next_s.ch[i] = CH_LATCH; // Illegal code fails off
      endcase
    end

    // Cross link: low rail fault holds high rail until enable cycles
    // After the loop so it wins over a same-cycle high rail restart
    if (timer_done[1] && !s.cfg[CFG_XLINK_DIS]) begin
      next_s.ch[0] = CH_LATCH;
    end
  end

  // State register; power-on load of defaults
  // A rail already on at release reads as a turn-on and sets its
  // flags on the first edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '{cfg: SYS_CFG_RST, ch_flags: 8'h00, oc_flags: 8'h00,
             fast_cnt: '0, tick_cnt: '0, ch: '{CH_RUN, CH_RUN},
             wait_cnt: '0, on_q: 2'b00, en_q: 2'b00, boost: 1'b0,
             limit_q: 1'b0};
    end else begin
      s <= next_s;
    end
  end

endmodule

// *** verif/hotswap_regs_props.sv ***
// Port-level assertions for the hot-swap status register block
`timescale 1ns/1ns
module hotswap_regs_props
  import hotswap_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       high_rail_enable,
  input wire logic [3:0] high_rail_limit_code,
  input wire logic       high_rail_on,
  input wire logic       high_rail_timer_done,
  input wire logic       low_rail_timer_done,
  input wire logic       low_rail_reverse,
  input wire logic       fast_off_drive,
  input wire logic       high_rail_allow,
  input wire logic       low_rail_allow,
  input wire logic [3:0] high_rail_limit_eff,
  input wire logic       low_rail_reverse_off,
  input wire logic       low_rail_oring_active
);
  // One clock domain; reset mutes every check
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  // Acks may only move while the serial clock is low
  chk_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data pin moved while serial clock high");
  chk_high_needs_en: assert property (
    high_rail_allow |-> high_rail_enable)
    else $error("high rail allowed while disabled");
  chk_high_timeout_off: assert property (
    high_rail_timer_done |=> !high_rail_allow)
    else $error("high rail still allowed after timeout");
  chk_low_timeout_off: assert property (
    low_rail_timer_done |=> !low_rail_allow)
    else $error("low rail still allowed after timeout");
  chk_reverse_gate: assert property (
    low_rail_reverse_off == (low_rail_reverse && low_rail_oring_active))
    else $error("reverse turnoff not gated by oring enable");
  chk_boost_code: assert property (
    high_rail_limit_eff == high_rail_limit_code ||
    high_rail_limit_eff == LIMIT_MAX)
    else $error("limit code neither programmed nor maximum");
  chk_boost_end: assert property (
    high_rail_timer_done |=> high_rail_limit_eff == high_rail_limit_code)
    else $error("boost outlived the fault timer");
  chk_fast_off_window: assert property (
    $fell(high_rail_on) |=> fast_off_drive [*8])
    else $error("fast turnoff not held after turn-off");
endmodule

bind hotswap_regs hotswap_regs_props i_props (
  .clock(clock), .rst(rst), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .high_rail_enable(high_rail_enable),
  .high_rail_limit_code(high_rail_limit_code),
  .high_rail_on(high_rail_on),
  .high_rail_timer_done(high_rail_timer_done),
  .low_rail_timer_done(low_rail_timer_done),
  .low_rail_reverse(low_rail_reverse), .fast_off_drive(fast_off_drive),
  .high_rail_allow(high_rail_allow), .low_rail_allow(low_rail_allow),
  .high_rail_limit_eff(high_rail_limit_eff),
  .low_rail_reverse_off(low_rail_reverse_off),
  .low_rail_oring_active(low_rail_oring_active)
);

// *** verif/serial_host.sv ***
// Two-wire serial host model for the register port
`timescale 1ns/1ns
module serial_host #(
  parameter logic [6:0] DEV = 7'h2A  // Arbitrary value
) (
  input  wire logic  clock,
  input  wire logic  sda_oe,
  output logic       scl,
  output logic       sda,
  output logic       rd_valid,
  output logic [7:0] rd_data,
  output int         nacks
);
  logic pull;
  // Pull-up line: low when either party pulls
  assign sda = !(pull || sda_oe);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
    nacks = 0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Data moves mid-low so it never races a clock edge
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    pull = !b;
    tick(4);
    scl = 1'b1;
    tick(6);
    r = sda;
    scl = 1'b0;
  endtask
  // Start is frame(0,1), stop is frame(1,0)
  task automatic frame(input logic a, input logic b);
    tick(2);
    pull = a;
    tick(4);
    scl = 1'b1;
    tick(6);
    pull = b;
    tick(6);
    scl = !b;
  endtask
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(last, ack);
  endtask
  task automatic send(input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    xfer(d, 1'b1, q, a);
    nacks += int'(a);
  endtask
  task automatic write_reg(input logic [7:0] off, input logic [7:0] d);
    frame(1'b0, 1'b1);
    send({DEV, 1'b0});
    send(off);
    send(d);
    frame(1'b1, 1'b0);
  endtask
  // One byte read, ended by a NACK
  task automatic read_reg(input logic [7:0] off);
    logic [7:0] q;
    logic       a;
    frame(1'b0, 1'b1);
    send({DEV, 1'b0});
    send(off);
    frame(1'b0, 1'b1);
    send({DEV, 1'b1});
    xfer(8'hFF, 1'b1, q, a);
    frame(1'b1, 1'b0);
    rd_data = q;
    rd_valid = 1'b1;
    tick(1);
    rd_valid = 1'b0;
  endtask
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the hot-swap status register block
`timescale 1ns/1ns
module testbench;
  import hotswap_pkg::*;
  localparam int TICK  = 4;
  localparam int RETRY = RETRY_FACTOR * TICK;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       hi_en, lo_en, hi_on, lo_on, rev;
  logic [3:0] lim, fet, lim_eff;
  logic [4:0] lo_code;
  logic [7:0] ev, d, rd_data;
  logic       scl, sda, sda_out, sda_oe, rd_valid;
  logic       fast_off, hi_allow, lo_allow, rev_off, oring_act;
  logic [2:0] obs;
  logic [7:0] exp_q[$];
  int         bad_count = 0;
  int         checks = 0;
  int         cycles = 0;
  int         seed = 91553;
  int         nacks, n;
  assign obs = {fast_off, lo_allow, hi_allow};
  always #5 clock = ~clock;
  hotswap_regs #(.FAULT_TICK(TICK), .DEV_ADDR(7'h2A)) i_dut (
    .clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .high_rail_enable(hi_en), .low_rail_enable(lo_en),
    .high_rail_fault_code(5'h01), .low_rail_fault_code(lo_code),
    .high_rail_limit_code(lim), .high_rail_on(hi_on), .low_rail_on(lo_on),
    .high_rail_pg_low(ev[0]), .high_rail_timer_done(ev[1]),
    .low_rail_pg_low(ev[2]), .low_rail_timer_done(ev[3]),
    .high_rail_in_limit(ev[4]), .high_rail_trip(ev[5]),
    .low_rail_in_limit(ev[6]), .low_rail_trip(ev[7]),
    .low_rail_reverse(rev), .high_rail_block_cmd(fet[0]),
    .high_rail_series_on(fet[1]), .low_rail_oring_on(fet[2]),
    .low_rail_gate_on(fet[3]), .fast_off_drive(fast_off),
    .high_rail_allow(hi_allow), .low_rail_allow(lo_allow),
    .high_rail_limit_eff(lim_eff), .low_rail_reverse_off(rev_off),
    .low_rail_oring_active(oring_act));
  serial_host #(.DEV(7'h2A)) i_host (
    .clock(clock), .sda_oe(sda_oe), .scl(scl), .sda(sda),
    .rd_valid(rd_valid), .rd_data(rd_data), .nacks(nacks));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Expected byte queued before the read is issued
  task automatic rd(input logic [7:0] off, input logic [7:0] exp);
    exp_q.push_back(exp);
    i_host.read_reg(off);
  endtask
  task automatic wr(input logic [7:0] v);
    i_host.write_reg(SYS_CFG_OFF, v);
  endtask
  task automatic pulse(input int k);
    @(negedge clock);
    ev[k] = 1'b1;
    @(negedge clock);
    ev[k] = 1'b0;
  endtask
  task automatic cycle_en();
    @(negedge clock);
    hi_en = 1'b0;
    lo_en = 1'b0;
    repeat (2) @(negedge clock);
    hi_en = 1'b1;
    lo_en = 1'b1;
    @(negedge clock);
  endtask
  // Bounded wait for one observed output to reach a level
  task automatic span(input int k, input logic v, output int c);
    c = 0;
    while (obs[k] !== v && c < 5000) begin
      @(negedge clock);
      c++;
    end
  endtask
  // Read results compared oldest first
  always @(posedge clock) begin
    if (rd_valid === 1'b1) cmp(rd_data, exp_q.pop_front());
  end
  // Hang guard, well above the expected run length
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    {hi_en, lo_en, hi_on, lo_on, rev} = 5'b11000;
    ev = 8'h00;
    fet = 4'h0;
    lim = 4'($random(seed));
    lo_code = 5'h01 + 5'($unsigned($random(seed)) % 3);
    repeat (3) @(negedge clock);
    rst = 1'b0;
    rd(SYS_CFG_OFF, SYS_CFG_RST);
    rd(CH_STAT_OFF, 8'h00);
    rd(OC_STAT_OFF, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      d = (8'($random(seed)) & 8'hDA) | 8'h20;
      rev = 1'($random(seed));
      wr(d);
      rd(SYS_CFG_OFF, d);
      cmp(oring_act, d[3]);
      cmp(rev_off, rev & d[3]);
    end
    i_host.write_reg(CH_STAT_OFF, 8'hFF);
    i_host.write_reg(FET_STAT_OFF, 8'hFF);
    rd(CH_STAT_OFF, 8'h00);
    rd(8'h0B, 8'h00);
    rd(SYS_CFG_OFF, d);
    $display("config test done");
    wr(8'h20);
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      d = 8'(8'h10 << (i % 4));
      rd(8'(CH_STAT_OFF + i / 4), d);
      rd(8'(CH_STAT_OFF + i / 4), 8'h00);
    end
    @(negedge clock);
    hi_on = 1'b1;
    rd(CH_STAT_OFF, 8'h10);
    rd(OC_STAT_OFF, 8'h30);
    rd(CH_STAT_OFF, 8'h00);
    @(negedge clock);
    lo_on = 1'b1;
    rd(CH_STAT_OFF, 8'h40);
    $display("latched flag test done");
    for (int i = 0; i < 4; i++) begin
      fet = 4'($random(seed));
      d = {~fet[3], 1'b0, ~fet[2], ~fet[1], fet[0], 3'h0};
      rd(FET_STAT_OFF, d);
    end
    $display("fet status test done");
    wr(8'h22);
    cycle_en();
    pulse(1);
    span(0, 1'b1, n);
    cmp(n >= RETRY - 2 * TICK && n <= RETRY + 3 * TICK, 1'b1);
    pulse(3);
    span(1, 1'b1, n);
    n -= RETRY * int'(lo_code);
    cmp(n >= -2 * TICK && n <= 3 * TICK, 1'b1);
    cmp(hi_allow, 1'b0);
    cycle_en();
    cmp(hi_allow, 1'b1);
    wr(8'h30);
    ev[4] = 1'b1;
    cycle_en();
    cmp(lim_eff, LIMIT_MAX);
    pulse(1);
    cmp(lim_eff, lim);
    repeat (RETRY + 8 * TICK) @(negedge clock);
    cmp(hi_allow, 1'b0);
    ev[4] = 1'b0;
    cycle_en();
    cmp(hi_allow, 1'b1);
    wr(8'hA0);
    pulse(3);
    repeat (4) @(negedge clock);
    cmp(hi_allow, 1'b1);
    cmp(lo_allow, 1'b0);
    $display("restart test done");
    wr(8'h21);
    repeat (2000) @(negedge clock);
    cmp(fast_off, 1'b1);
    wr(8'h20);
    cmp(fast_off, 1'b0);
    hi_on = 1'b0;
    repeat (2) @(negedge clock);
    span(2, 1'b0, n);
    n = n + 2 - FAST_OFF_CYCLES;
    cmp(n >= -5 && n <= 5, 1'b1);
    cmp(16'(nacks), 16'h0000);
    $display("fast turnoff test done");
    repeat (4) @(negedge clock);
    finish_test();
  end
endmodule
